// File: umx_cfg.svh
// offsets, field positions, reset values and counts of the extended-mode control
// assumes byte-wide registers reached at their printed offsets over a plain port
`ifndef UMX_CFG_SVH
`define UMX_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define UMX_OFS_BAUD_FIRST    4'h2
`define UMX_OFS_BAUD_SECOND   4'h3
`define UMX_OFS_BREAK_NODE    4'h7
`define UMX_OFS_SPECIAL_MODE  4'h8
`define UMX_OFS_LIN_SLAVE     4'h9
`define UMX_OFS_GUARD_TIME    4'hA
`define UMX_OFS_PRESCALER     4'hB
`define UMX_OFS_GUARD_TIME_U1 4'h9
`define UMX_OFS_PRESCALER_U1  4'hA

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UMX_BIT_BREAK_LEN     5
`define UMX_BIT_SMARTCARD     5
`define UMX_BIT_NACK          4
`define UMX_BIT_HALF_DUPLEX   3
`define UMX_BIT_IRDA_LP       2
`define UMX_BIT_IRDA_EN       1
`define UMX_BIT_DIV_METHOD    7
`define UMX_BIT_LIN_SLAVE     5
`define UMX_BIT_AUTO_RESYNC   4
`define UMX_BIT_HDR_IRQ_EN    2
`define UMX_BIT_HDR_FLAG      1
`define UMX_BIT_SYNC_FLAG     0
`define UMX_SC_PSC_MSB        4

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define UMX_RST_BYTE          8'h00
`define UMX_RST_DIV           16'h0000
`define UMX_BREAK_BITS_SHORT  5'h0A
`define UMX_BREAK_BITS_LONG   5'h0B
`define UMX_SYNC_EDGES        3'h5
`define UMX_SYNC_BITS_LOG2    3

`endif

// File: umx_pkg.sv
// types shared by the extended-mode control and its users
// assumes the constants header is included where numbers are needed
package umx_pkg;

   // lin header tracking, one-hot
   typedef enum logic [2:0] {
      UMX_IDLE  = 3'b001,
      UMX_SYNC  = 3'b010,
      UMX_IDENT = 3'b100
   } umx_lin_state_e;

   // mode levels handed to the serial datapath
   typedef struct packed {
      logic half_duplex;
      logic smartcard;
      logic irda;
      logic irda_low_power;
      logic lin_slave;
      logic auto_resync;
   } umx_mode_s;

endpackage : umx_pkg

// File: umx_ctrl.sv
// extended-mode control of a byte-wide uart: smartcard, irda, half duplex,
// guard time, prescaler and lin slave header tracking
// assumes the core datapath reports received characters, parity errors and
// transmit completion as one-cycle pulses on this clock
//
// Added by the designer: the address-and-strobe port.
`include "umx_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module umx_ctrl #(
   parameter bit FIRST_INSTANCE  = 1'b0,
   parameter bit HAS_HALF_DUPLEX = 1'b1
) (
   input  wire logic             core_clk_i,
   input  wire logic             nrst_i,
   input  wire logic [3:0]       reg_addr_i,
   input  wire logic [7:0]       reg_wdata_i,
   input  wire logic             reg_wr_i,
   input  wire logic             reg_rd_i,
   output var  logic [7:0]       reg_rdata_o,
   input  wire logic             receive_data_line_i,
   input  wire logic             rx_char_done_i,
   input  wire logic             parity_error_i,
   input  wire logic             tx_done_i,
   output var  umx_pkg::umx_mode_s mode_o,
   output var  logic [15:0]      lin_baud_divider_o,
   output var  logic             baud_tick_o,
   output var  logic             nack_o,
   output var  logic             transmission_complete_set_o,
   output var  logic             card_clk_o,
   output var  logic             irda_lp_tick_o,
   output var  logic             header_irq_o
);
   import umx_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // a zero divider would stall the counters, so it counts as one
   function automatic logic [15:0] div_or_one(input logic [15:0] v);
      div_or_one = (v == 16'h0000) ? 16'h0001 : v;
   endfunction : div_or_one

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [7:0]     baud_first_reg;
   logic [7:0]     baud_second_reg;
   logic           break_len_reg;
   logic           smartcard_reg;
   logic           nack_en_reg;
   logic           half_duplex_reg;
   logic           irda_lp_reg;
   logic           irda_en_reg;
   logic           div_method_reg;
   logic           lin_slave_reg;
   logic           auto_resync_reg;
   logic           hdr_irq_en_reg;
   logic           hdr_flag_reg;
   logic           sync_flag_reg;
   logic [7:0]     guard_time_reg;
   logic [7:0]     prescaler_reg;
   logic [7:0]     rdata_reg;
   logic [15:0]    lin_div_reg;
   logic           div_pending_reg;
   logic [15:0]    baud_cnt_reg;
   logic           baud_tick_reg;
   logic           rx_prev_reg;
   logic [4:0]     low_bits_reg;
   logic           break_seen_reg;
   umx_lin_state_e lin_state_reg;
   logic [2:0]     edge_cnt_reg;
   logic [18:0]    sync_cnt_reg;
   logic           resync_load;
   logic [15:0]    measured_div;
   logic           break_detect;
   logic [7:0]     gt_cnt_reg;
   logic           gt_busy_reg;
   logic           tc_set_reg;
   logic           nack_reg;
   logic [7:0]     psc_cnt_reg;
   logic           card_clk_reg;
   logic           irda_tick_reg;
   umx_mode_s      mode_reg;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic       has_lin;
   logic [3:0] ofs_guard;
   logic [3:0] ofs_psc;
   logic       wr_first;
   logic       wr_second;
   logic       wr_break;
   logic       wr_special;
   logic       wr_lin;
   logic       wr_guard;
   logic       wr_psc;
   logic       falling;

   assign has_lin    = !FIRST_INSTANCE;
   assign ofs_guard  = FIRST_INSTANCE ? `UMX_OFS_GUARD_TIME_U1 : `UMX_OFS_GUARD_TIME;
   assign ofs_psc    = FIRST_INSTANCE ? `UMX_OFS_PRESCALER_U1 : `UMX_OFS_PRESCALER;
   assign wr_first   = reg_wr_i && (reg_addr_i == `UMX_OFS_BAUD_FIRST);
   assign wr_second  = reg_wr_i && (reg_addr_i == `UMX_OFS_BAUD_SECOND);
   assign wr_break   = reg_wr_i && (reg_addr_i == `UMX_OFS_BREAK_NODE);
   assign wr_special = reg_wr_i && (reg_addr_i == `UMX_OFS_SPECIAL_MODE);
   assign wr_lin     = reg_wr_i && has_lin && (reg_addr_i == `UMX_OFS_LIN_SLAVE);
   assign wr_guard   = reg_wr_i && (reg_addr_i == ofs_guard);
   assign wr_psc     = reg_wr_i && (reg_addr_i == ofs_psc);
   assign falling    = rx_prev_reg && !receive_data_line_i;

   // ----------------------------------------------------------------
   // software controls
   // ----------------------------------------------------------------
   // reserved bits are not stored and read back as zero
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         baud_first_reg  <= `UMX_RST_BYTE;
         baud_second_reg <= `UMX_RST_BYTE;
         break_len_reg   <= 1'b0;
         smartcard_reg   <= 1'b0;
         nack_en_reg     <= 1'b0;
         half_duplex_reg <= 1'b0;
         irda_lp_reg     <= 1'b0;
         irda_en_reg     <= 1'b0;
         lin_slave_reg   <= 1'b0;
         auto_resync_reg <= 1'b0;
         hdr_irq_en_reg  <= 1'b0;
         guard_time_reg  <= `UMX_RST_BYTE;
         prescaler_reg   <= `UMX_RST_BYTE;
      end else begin
         if (wr_first) baud_first_reg <= reg_wdata_i;
         if (wr_second) baud_second_reg <= reg_wdata_i;
         if (wr_break) break_len_reg <= reg_wdata_i[`UMX_BIT_BREAK_LEN];
         if (wr_special) begin
            smartcard_reg   <= reg_wdata_i[`UMX_BIT_SMARTCARD];
            nack_en_reg     <= reg_wdata_i[`UMX_BIT_NACK];
            half_duplex_reg <= HAS_HALF_DUPLEX && reg_wdata_i[`UMX_BIT_HALF_DUPLEX];
            irda_lp_reg     <= reg_wdata_i[`UMX_BIT_IRDA_LP];
            irda_en_reg     <= reg_wdata_i[`UMX_BIT_IRDA_EN];
         end
         if (wr_lin) begin
            lin_slave_reg   <= reg_wdata_i[`UMX_BIT_LIN_SLAVE];
            auto_resync_reg <= reg_wdata_i[`UMX_BIT_AUTO_RESYNC];
            hdr_irq_en_reg  <= reg_wdata_i[`UMX_BIT_HDR_IRQ_EN];
         end
         if (wr_guard) guard_time_reg <= reg_wdata_i;
         if (wr_psc) prescaler_reg <= reg_wdata_i;
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   // data stand only in the cycle after the strobe, zero elsewhere
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_reg <= `UMX_RST_BYTE;
      end else if (!reg_rd_i) begin
         rdata_reg <= `UMX_RST_BYTE;
      end else if (reg_addr_i == `UMX_OFS_BAUD_FIRST) begin
         rdata_reg <= baud_first_reg;
      end else if (reg_addr_i == `UMX_OFS_BAUD_SECOND) begin
         rdata_reg <= baud_second_reg;
      end else if (reg_addr_i == `UMX_OFS_BREAK_NODE) begin
         rdata_reg <= 8'(break_len_reg) << `UMX_BIT_BREAK_LEN;
      end else if (reg_addr_i == `UMX_OFS_SPECIAL_MODE) begin
         rdata_reg <= (8'(smartcard_reg) << `UMX_BIT_SMARTCARD) | (8'(nack_en_reg) << `UMX_BIT_NACK)
                    | (8'(half_duplex_reg) << `UMX_BIT_HALF_DUPLEX) | (8'(irda_lp_reg) << `UMX_BIT_IRDA_LP)
                    | (8'(irda_en_reg) << `UMX_BIT_IRDA_EN);
      end else if (has_lin && reg_addr_i == `UMX_OFS_LIN_SLAVE) begin
         rdata_reg <= (8'(div_method_reg) << `UMX_BIT_DIV_METHOD) | (8'(lin_slave_reg) << `UMX_BIT_LIN_SLAVE)
                    | (8'(auto_resync_reg) << `UMX_BIT_AUTO_RESYNC) | (8'(hdr_irq_en_reg) << `UMX_BIT_HDR_IRQ_EN)
                    | (8'(hdr_flag_reg) << `UMX_BIT_HDR_FLAG) | (8'(sync_flag_reg) << `UMX_BIT_SYNC_FLAG);
      end else if (reg_addr_i == ofs_guard) begin
         rdata_reg <= guard_time_reg;
      end else if (reg_addr_i == ofs_psc) begin
         rdata_reg <= prescaler_reg;
      end else begin
         rdata_reg <= `UMX_RST_BYTE;
      end
   end

   // ----------------------------------------------------------------
   // lin baud divider
   // ----------------------------------------------------------------
   // the measured rate wins over a software load in the same cycle
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lin_div_reg     <= `UMX_RST_DIV;
         div_pending_reg <= 1'b0;
      end else if (resync_load) begin
         lin_div_reg     <= measured_div;
         div_pending_reg <= 1'b0;
      end else if (wr_first && !div_method_reg) begin
         lin_div_reg <= {baud_second_reg[7:4], reg_wdata_i, baud_second_reg[3:0]};
      end else if (wr_first) begin
         div_pending_reg <= 1'b1;
      end else if (div_pending_reg && rx_char_done_i) begin
         lin_div_reg     <= {baud_second_reg[7:4], baud_first_reg, baud_second_reg[3:0]};
         div_pending_reg <= 1'b0;
      end
   end

   // method bit: software writes it, hardware drops it after a resync load
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_method_reg <= 1'b0;
      end else if (resync_load) begin
         div_method_reg <= 1'b0;
      end else if (wr_lin) begin
         div_method_reg <= reg_wdata_i[`UMX_BIT_DIV_METHOD];
      end
   end

   // bit-time tick, one system clock per divider count
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         baud_cnt_reg  <= `UMX_RST_DIV;
         baud_tick_reg <= 1'b0;
      end else if (baud_cnt_reg + 16'h0001 >= div_or_one(lin_div_reg)) begin
         baud_cnt_reg  <= `UMX_RST_DIV;
         baud_tick_reg <= 1'b1;
      end else begin
         baud_cnt_reg  <= baud_cnt_reg + 16'h0001;
         baud_tick_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // break detection
   // ----------------------------------------------------------------
   // counts whole bit times of low line; one detection per low period
   assign break_detect = lin_slave_reg && has_lin && !break_seen_reg && baud_tick_reg && !receive_data_line_i
                         && (low_bits_reg + 5'h01 == (break_len_reg ? `UMX_BREAK_BITS_LONG
                                                                    : `UMX_BREAK_BITS_SHORT));

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_prev_reg    <= 1'b1;
         low_bits_reg   <= 5'h00;
         break_seen_reg <= 1'b0;
      end else begin
         rx_prev_reg <= receive_data_line_i;
         if (receive_data_line_i) begin
            low_bits_reg   <= 5'h00;
            break_seen_reg <= 1'b0;
         end else if (break_detect) begin
            break_seen_reg <= 1'b1;
         end else if (baud_tick_reg && !break_seen_reg) begin
            low_bits_reg <= low_bits_reg + 5'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // header tracking
   // ----------------------------------------------------------------
   // five falling edges of the sync byte span eight bit times
   assign measured_div = sync_cnt_reg[15 + `UMX_SYNC_BITS_LOG2 : `UMX_SYNC_BITS_LOG2];
   assign resync_load  = (lin_state_reg == UMX_SYNC) && auto_resync_reg && falling
                         && (edge_cnt_reg + 3'h1 == `UMX_SYNC_EDGES);

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lin_state_reg <= UMX_IDLE;
         edge_cnt_reg  <= 3'h0;
         sync_cnt_reg  <= 19'h00000;
      end else if (break_detect) begin
         lin_state_reg <= UMX_SYNC;
         edge_cnt_reg  <= 3'h0;
         sync_cnt_reg  <= 19'h00000;
      end else begin
         unique case (lin_state_reg)
            UMX_IDLE: begin
               edge_cnt_reg <= 3'h0;
            end
            UMX_SYNC: begin
               if (wr_lin && !reg_wdata_i[`UMX_BIT_SYNC_FLAG]) begin
                  lin_state_reg <= UMX_IDLE;
               end else if (resync_load) begin
                  lin_state_reg <= UMX_IDENT;
               end else if (auto_resync_reg) begin
                  if (falling) edge_cnt_reg <= edge_cnt_reg + 3'h1;
                  // the first edge counts too, so the span is the whole eight bit times
                  if (edge_cnt_reg != 3'h0 || falling) sync_cnt_reg <= sync_cnt_reg + 19'h00001;
               end else if (rx_char_done_i) begin
                  lin_state_reg <= UMX_IDENT;
               end
            end
            UMX_IDENT: begin
               if (rx_char_done_i) lin_state_reg <= UMX_IDLE;
            end
            default: begin
               lin_state_reg <= UMX_IDLE;
            end
         endcase
      end
   end

   // sync flag: set at break, dropped when analysis ends or software writes zero
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync_flag_reg <= 1'b0;
      end else if (break_detect) begin
         sync_flag_reg <= 1'b1;
      end else if (lin_state_reg == UMX_SYNC && (resync_load || (!auto_resync_reg && rx_char_done_i))) begin
         sync_flag_reg <= 1'b0;
      end else if (wr_lin && !reg_wdata_i[`UMX_BIT_SYNC_FLAG]) begin
         sync_flag_reg <= 1'b0;
      end
   end

   // header flag: a set in the clearing cycle wins
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hdr_flag_reg <= 1'b0;
      end else if (lin_state_reg == UMX_IDENT && rx_char_done_i) begin
         hdr_flag_reg <= 1'b1;
      end else if (wr_lin && !reg_wdata_i[`UMX_BIT_HDR_FLAG]) begin
         hdr_flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // smartcard guard time and nack
   // ----------------------------------------------------------------
   // completion is held back by the guard count of bit ticks
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gt_cnt_reg  <= `UMX_RST_BYTE;
         gt_busy_reg <= 1'b0;
         tc_set_reg  <= 1'b0;
      end else if (tx_done_i && (!smartcard_reg || guard_time_reg == 8'h00)) begin
         gt_busy_reg <= 1'b0;
         tc_set_reg  <= 1'b1;
      end else if (tx_done_i) begin
         gt_cnt_reg  <= guard_time_reg;
         gt_busy_reg <= 1'b1;
         tc_set_reg  <= 1'b0;
      end else if (gt_busy_reg && baud_tick_reg) begin
         gt_cnt_reg  <= gt_cnt_reg - 8'h01;
         gt_busy_reg <= (gt_cnt_reg != 8'h01);
         tc_set_reg  <= (gt_cnt_reg == 8'h01);
      end else begin
         tc_set_reg <= 1'b0;
      end
   end

   // nack request is a one-cycle pulse to the transmitter
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         nack_reg <= 1'b0;
      end else begin
         nack_reg <= smartcard_reg && nack_en_reg && parity_error_i;
      end
   end

   // ----------------------------------------------------------------
   // prescaler
   // ----------------------------------------------------------------
   // one counter serves both uses; smartcard takes priority when both are on
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         psc_cnt_reg   <= `UMX_RST_BYTE;
         card_clk_reg  <= 1'b0;
         irda_tick_reg <= 1'b0;
      end else if (smartcard_reg) begin
         irda_tick_reg <= 1'b0;
         if (16'(psc_cnt_reg) + 16'h0001 >= div_or_one(16'(prescaler_reg[`UMX_SC_PSC_MSB:0]))) begin
            psc_cnt_reg  <= `UMX_RST_BYTE;
            card_clk_reg <= !card_clk_reg;
         end else begin
            psc_cnt_reg <= psc_cnt_reg + 8'h01;
         end
      end else if (irda_en_reg && irda_lp_reg) begin
         card_clk_reg <= 1'b0;
         if (16'(psc_cnt_reg) + 16'h0001 >= div_or_one(16'(prescaler_reg))) begin
            psc_cnt_reg   <= `UMX_RST_BYTE;
            irda_tick_reg <= 1'b1;
         end else begin
            psc_cnt_reg   <= psc_cnt_reg + 8'h01;
            irda_tick_reg <= 1'b0;
         end
      end else begin
         psc_cnt_reg   <= `UMX_RST_BYTE;
         card_clk_reg  <= 1'b0;
         irda_tick_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // mode levels and interrupt
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mode_reg     <= '0;
         header_irq_o <= 1'b0;
      end else begin
         mode_reg.half_duplex    <= half_duplex_reg;
         mode_reg.smartcard      <= smartcard_reg;
         mode_reg.irda           <= irda_en_reg;
         mode_reg.irda_low_power <= irda_lp_reg;
         mode_reg.lin_slave      <= lin_slave_reg;
         mode_reg.auto_resync    <= auto_resync_reg;
         header_irq_o            <= hdr_flag_reg && hdr_irq_en_reg;
      end
   end

   // all outputs below come straight from flip-flops
   assign reg_rdata_o                 = rdata_reg;
   assign mode_o                      = mode_reg;
   assign lin_baud_divider_o          = lin_div_reg;
   assign baud_tick_o                 = baud_tick_reg;
   assign nack_o                      = nack_reg;
   assign transmission_complete_set_o = tc_set_reg;
   assign card_clk_o                  = card_clk_reg;
   assign irda_lp_tick_o              = irda_tick_reg;

endmodule : umx_ctrl

`default_nettype wire

// File: umx_ctrl_props.sv
// checker on the ports of the extended-mode control
// assumes it is bound onto every umx_ctrl
`timescale 1ns/100ps
`default_nettype none
module umx_ctrl_props (
   input wire logic               core_clk_i,
   input wire logic               nrst_i,
   input wire logic [3:0]         reg_addr_i,
   input wire logic               reg_wr_i,
   input wire logic               reg_rd_i,
   input wire logic [7:0]         reg_rdata_o,
   input wire logic               parity_error_i,
   input wire logic               tx_done_i,
   input wire umx_pkg::umx_mode_s mode_o,
   input wire logic               nack_o,
   input wire logic               transmission_complete_set_o,
   input wire logic               card_clk_o,
   input wire logic               irda_lp_tick_o
);
   import umx_pkg::*;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   // smartcard settled off, no write that could turn it on in flight
   sequence s_sc_off;
      !mode_o.smartcard && !$past(reg_wr_i);
   endsequence
   a_rsvd_read_zero: assert property ($past(reg_rd_i && reg_addr_i == 4'h8) |->
      reg_rdata_o[7:6] == 2'h0 && !reg_rdata_o[0]) else $error("reserved bit set");
   a_rdata_after_read: assert property (reg_rdata_o != 8'h00 |-> $past(reg_rd_i))
      else $error("read data without read");
   a_nack_has_cause: assert property (nack_o |-> $past(parity_error_i)) else $error("stray nack");
   a_nack_sc_off: assert property (parity_error_i ##0 s_sc_off |=> !nack_o) else $error("nack off mode");
   a_tc_no_guard: assert property (tx_done_i ##0 s_sc_off |=> transmission_complete_set_o)
      else $error("complete not next cycle");
   a_tc_one_pulse: assert property (transmission_complete_set_o |=> !transmission_complete_set_o)
      else $error("complete too long");
   a_card_clk_idle: assert property (!mode_o.smartcard && !$past(mode_o.smartcard) |-> !card_clk_o)
      else $error("card clock off mode");
   a_irda_tick_gate: assert property (irda_lp_tick_o |-> (mode_o.irda_low_power ||
      $past(mode_o.irda_low_power))) else $error("tick off mode");
endmodule : umx_ctrl_props
bind umx_ctrl umx_ctrl_props u_props (.*);
`default_nettype wire

// File: umx_lin_master.sv
// lin master model on the receive line
// assumes the bench calls send_header just after a clock edge
`timescale 1ns/100ps
`default_nettype none
module umx_lin_master (
   input wire logic core_clk_i,
   output var logic line_o
);
   initial line_o = 1'b1; // idle high between frames
   // break of 13 low bits, delimiter, then the 0x55 sync byte
   task automatic send_header(input int bit_clks);
      logic [23:0] f;
      f = {1'b1, 8'h55, 1'b0, 1'b1, 13'h0000};
      for (int i = 0; i < 24; i++) begin
         line_o <= f[i];
         repeat (bit_clks) @(posedge core_clk_i);
      end
   endtask : send_header
endmodule : umx_lin_master
`default_nettype wire

// File: umx_ctrl_tb.sv
// bench: registers, modes, guard, prescaler, lin header
// assumes default parameters and the lin model on the line
`timescale 1ns/100ps
`default_nettype none
module umx_ctrl_tb;
   import umx_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rxc = 1'b0, par = 1'b0, txd = 1'b0;
   logic rxd, nack, tc, cclk, itick, irq, btick;
   logic [3:0] addr = 4'h0;
   logic [7:0] wd = 8'h00, rdata;
   logic [15:0] div;
   umx_mode_s mode;
   int miscompares = 0, n_tests = 0, cyc = 0, k;
   // offset, write data, read back
   logic [19:0] rows [6] = '{20'h8FF3E, 20'h9FFB4, 20'hA5A5A, 20'hBA5A5, 20'h5FF00, 20'h7FF20};
   umx_ctrl u_dut (.core_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wdata_i(wd),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .receive_data_line_i(rxd),
      .rx_char_done_i(rxc), .parity_error_i(par), .tx_done_i(txd), .mode_o(mode),
      .lin_baud_divider_o(div), .baud_tick_o(btick), .nack_o(nack), .transmission_complete_set_o(tc),
      .card_clk_o(cclk), .irda_lp_tick_o(itick), .header_irq_o(irq));
   umx_lin_master u_lin (.core_clk_i(clk), .line_o(rxd));
   initial forever #50 clk = ~clk;
   // hang guard, far above the run length
   always @(posedge clk) if (++cyc == 5000) begin
      miscompares++;
      close_out();
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk) addr <= a;
      wd <= d;
      wr <= 1'b1;
   endtask : wr_reg
   // data stand only in the cycle after the taking edge
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk) addr <= a;
      rd <= 1'b1;
      wr <= 1'b0;
      @(posedge clk) rd <= 1'b0;
      #1 chk(rdata, e);
   endtask : rd_reg
   task automatic idle(input int n);
      repeat (n) @(posedge clk) wr <= 1'b0;
   endtask : idle
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      for (k = 8; k < 12; k++) rd_reg(k[3:0], 8'h00);
      foreach (rows[i]) begin
         wr_reg(rows[i][19:16], rows[i][15:8]);
         rd_reg(rows[i][19:16], rows[i][7:0]);
      end
      chk(mode, 16'h003F);
      wr_reg(4'h9, 8'h00);
      wr_reg(4'h3, 8'h04);
      wr_reg(4'h2, 8'h00);
      wr_reg(4'hA, 8'h03);
      wr_reg(4'h8, 8'h30);
      idle(3);
      chk(div, 16'h0004);
      k = 0;
      repeat (40) @(posedge clk) k += int'(btick);
      chk(k[15:0], 16'd10);
      par <= 1'b1;
      @(posedge clk) par <= 1'b0;
      txd <= 1'b1;
      #1 chk(nack, 1'b1);
      @(posedge clk) txd <= 1'b0;
      for (k = 0; tc !== 1'b1 && k < 40; k++) @(posedge clk);
      chk(k inside {[10:14]}, 1'b1);
      k = 0;
      repeat (40) @(posedge clk) k += int'(cclk);
      chk(k, 16'd20);
      wr_reg(4'h8, 8'h06);
      wr_reg(4'hB, 8'h03);
      idle(4);
      k = 0;
      repeat (30) @(posedge clk) k += int'(itick);
      chk(k, 16'd10);
      par <= 1'b1;
      txd <= 1'b1;
      @(posedge clk) par <= 1'b0;
      txd <= 1'b0;
      wr_reg(4'h7, 8'h00);
      wr_reg(4'h9, 8'hB4);
      idle(2);
      u_lin.send_header(6);
      idle(2);
      chk(div, 16'h0006);
      rd_reg(4'h9, 8'h34);
      @(posedge clk) rxc <= 1'b1;
      @(posedge clk) rxc <= 1'b0;
      idle(2);
      chk(irq, 1'b1);
      rd_reg(4'h9, 8'h36);
      wr_reg(4'h9, 8'h34);
      rd_reg(4'h9, 8'h34);
      idle(2);
      chk(irq, 1'b0);
      wr_reg(4'h9, 8'hB4);
      wr_reg(4'h3, 8'h08);
      wr_reg(4'h2, 8'h00);
      idle(2);
      chk(div, 16'h0006);
      rxc <= 1'b1;
      @(posedge clk) rxc <= 1'b0;
      @(posedge clk) chk(div, 16'h0008);
      close_out();
   end
endmodule : umx_ctrl_tb
`default_nettype wire
